// ===== dv/relay_lowside_diag_ctrl_test.sv
// Purpose: Self-checking bench for the relay control block over Wishbone.
// Assumes: Shortened counts for hold, mask, filter and overcurrent times.
// Notes:   Loads come from the partner model; faults are chosen per channel.

`timescale 1ns/1ps
`default_nettype none

module relay_lowside_diag_ctrl_test;
  import rld_pkg::*;

  // ==========================================================================
  // Shortened counts, so the run stays short.
  localparam int HN = 200;
  localparam int MN = 20;
  localparam int DN = 10;
  localparam int ON = 5;

  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat, rd_dat, q;
  logic        dev_rst, bat_low, mcu_rst_n;
  logic [5:0]  ovc, low, high, drive;
  logic [1:0]  hold;
  logic [11:0] fault;               // Load condition per channel.
  int          n_mismatch, checked;

  rld_top #(.HOLD_N(HN), .DIAG_N(DN), .MASK_N(MN), .OVC_N(ON)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(rd_dat), .wb_ack_o(wb_ack), .device_reset_signal_i(dev_rst),
    .battery_low_level_i(bat_low), .mcu_reset_n_i(mcu_rst_n),
    .overcurrent_threshold_i(ovc), .out_below_low_i(low),
    .out_above_high_i(high), .drive_on_o(drive), .hold_active_o(hold));

  rld_load_model LOAD (.drive_i(drive), .fault_i(fault), .ovc_o(ovc),
    .low_o(low), .high_o(high));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    // No cycle count is assumed here; only the watchdog ends a stuck wait.
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = rd_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
    tick(3);
  endtask

  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask

  task automatic results;
    $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog; the tests need a few thousand cycles at most.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    tick(20000);
    n_mismatch++;
    results();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {dev_rst, bat_low, n_mismatch, checked} = '0;
    mcu_rst_n = 1'b1;
    fault = {6{FLT_NONE}};
    rst_i = 1'b1;
    tick(20);
    rst_i <= 1'b0;
    tick(1);
    // Reset values, an unmapped place and the all-clear fault word.
    rd(ADR_CMD);  check("cmd", q, 32'h0);
    rd(ADR_CFG);  check("cfg", q, 32'h0);
    rd(ADR_STAT); check("stat", q, 32'h0);
    rd(4'h2);     check("unmapped", q, 32'h0);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    // Commands reach the gates; a write without byte 0 is ignored.
    wr(ADR_CMD, 32'h3f); check("drive", 32'(drive), 32'h3f);
    wb(1'b1, ADR_CMD, 4'he, 32'h0); tick(3);
    check("drive", 32'(drive), 32'h3f);
    // Global disable and device reset force every gate off.
    wr(ADR_CFG, 32'h1); check("drive", 32'(drive), 32'h0);
    wr(ADR_CFG, 32'h0); check("drive", 32'(drive), 32'h3f);
    dev_rst <= 1'b1; tick(3); check("drive", 32'(drive), 32'h0);
    dev_rst <= 1'b0; tick(3); check("drive", 32'(drive), 32'h3f);
    // An overcurrent shorter than the filter restarts its count.
    fault[5:4] <= FLT_SGB; tick(ON - 1);
    fault[5:4] <= FLT_NONE; tick(3);
    check("drive", 32'(drive), 32'h3f);
    fault[5:4] <= FLT_SGB; tick(ON + 3);
    check("drive", 32'(drive), 32'h3b);
    fault[5:4] <= FLT_NONE; tick(MN + DN + 5);
    rd(ADR_DIAG); check("diag", q, 32'hfef);
    tick(2); check("drive", 32'(drive), 32'h3f);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    // Second cut-off, cleared by taking the command low then high.
    fault[5:4] <= FLT_SGB; tick(ON + 3);
    fault[5:4] <= FLT_NONE;
    wr(ADR_CMD, 32'h3b); check("drive", 32'(drive), 32'h3b);
    wr(ADR_CMD, 32'h3f); check("drive", 32'(drive), 32'h3f);
    rd(ADR_DIAG); check("diag", q, 32'hfef);
    // Off-state: ground seen only when off, masked, first fault kept.
    fault[7:6] <= FLT_SCG; tick(DN + 5);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    fault[7:6] <= FLT_OL;
    wr(ADR_CMD, 32'h37);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    tick(MN + DN + 5);
    fault[7:6] <= FLT_SCG; tick(DN + 5);
    rd(ADR_DIAG); check("diag", q, 32'hf7f);
    tick(DN + 5);
    rd(ADR_DIAG); check("diag", q, 32'hf3f);
    fault[7:6] <= FLT_NONE; tick(DN + 5);
    // The ground fault was still present when the last read cleared it, so
    // it latched again at once; only the read after that comes back clean.
    rd(ADR_DIAG); check("diag", q, 32'hf3f);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    fault[7:6] <= FLT_SCG; tick(DN - 1);
    fault[7:6] <= FLT_NONE; tick(DN + 5);
    rd(ADR_DIAG); check("diag", q, 32'hfff);
    // Low-battery hold on channel 13 only, left to expire.
    wr(ADR_CFG, 32'h2);
    wr(ADR_CMD, 32'h3);
    bat_low <= 1'b1; tick(2);
    mcu_rst_n <= 1'b0;
    dev_rst <= 1'b1; tick(5);
    check("drive", 32'(drive), 32'h1);
    check("hold", 32'(hold), 32'h1);
    rd(ADR_STAT); check("stat", q, 32'h101);
    tick(HN);
    check("drive", 32'(drive), 32'h0);
    check("hold", 32'(hold), 32'h0);
    rd(ADR_CMD); check("cmd", q, 32'h2);
    mcu_rst_n <= 1'b1;
    dev_rst <= 1'b0; tick(3);
    check("drive", 32'(drive), 32'h2);
    // Both holds enabled; the host retakes control in time.
    wr(ADR_CFG, 32'h6);
    wr(ADR_CMD, 32'h3);
    mcu_rst_n <= 1'b0;
    dev_rst <= 1'b1; tick(5);
    check("hold", 32'(hold), 32'h3);
    check("drive", 32'(drive), 32'h3);
    tick(50);
    mcu_rst_n <= 1'b1;
    dev_rst <= 1'b0;
    bat_low <= 1'b0;
    wr(ADR_CMD, 32'h3);
    tick(HN + 10);
    check("drive", 32'(drive), 32'h3);
    check("hold", 32'(hold), 32'h0);
    results();
  end
endmodule

`default_nettype wire

// ===== dv/rld_load_model.sv
// Purpose: Behavioural model of the six relay loads and their comparators.
// Assumes: Fault selection per channel uses the package fault codes.
// Notes:   Purely combinational; the bench picks each load's condition.

`timescale 1ns/1ps
`default_nettype none

module rld_load_model (
  input  wire logic [rld_pkg::NUM_CH-1:0]   drive_i,
  input  wire logic [2*rld_pkg::NUM_CH-1:0] fault_i,
  output logic      [rld_pkg::NUM_CH-1:0]   ovc_o,
  output logic      [rld_pkg::NUM_CH-1:0]   low_o,
  output logic      [rld_pkg::NUM_CH-1:0]   high_o
);
  import rld_pkg::*;

  // ==========================================================================
  // Comparator levels.
  // A driven output sits near ground, so the low comparator trips even on a
  // good load; the block must ignore the window while the gate is on.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ovc_o[i]  = drive_i[i] && (fault_i[2*i+:2] == FLT_SGB);
      low_o[i]  = drive_i[i] || (fault_i[2*i+:2] == FLT_SCG);
      high_o[i] = !drive_i[i] && (fault_i[2*i+:2] inside {FLT_NONE, FLT_SGB});
    end
  end
endmodule

`default_nettype wire

// ===== hdl/rld_chan.sv
// Purpose: One relay channel: overcurrent cut-off, off-state diagnosis, latch.
// Assumes: Comparator levels are synchronous to clk_i.
// Notes:   Counts are parameters so simulation may shorten them.

`timescale 1ns/1ps
`default_nettype none

module rld_chan
  import rld_pkg::*;
#(
  parameter int OVC_N  = OVC_FILT_CYC,
  parameter int DIAG_N = DIAG_FILT_CYC,
  parameter int MASK_N = MASK_CYC
) (
  input wire logic  clk_i,
  input wire logic  rst_i,
  rld_chan_if.chan  ch
);
  localparam int OW = $clog2(OVC_N + 1);
  localparam int DW = $clog2(DIAG_N + 1);
  localparam int MW = $clog2(MASK_N + 1);

  // ==========================================================================
  // State.
  logic          cmd_q, shut, drive_q;       // Command history, cut-off, gate.
  logic [OW-1:0] ovc_cnt;                    // On-state overcurrent filter.
  logic [MW-1:0] mask_cnt;                   // Mask delay after switch-off.
  logic [DW-1:0] off_cnt;                    // Off-state filter.
  logic [1:0]    cand, code;                 // Candidate and latched codes.
  logic          next_cmd_q, next_shut, next_drive;
  logic [OW-1:0] next_ovc_cnt;
  logic [MW-1:0] next_mask_cnt;
  logic [DW-1:0] next_off_cnt;
  logic [1:0]    next_cand, next_code, raw, base;
  logic          trip, off_evt, qual;

  // Next-state logic for the whole channel.
  always_comb begin
    // Overcurrent is watched only while the gate is on; the count restarts
    // whenever the comparator drops.
    trip         = drive_q && ch.ovc && (ovc_cnt == OW'(OVC_N - 1));
    next_ovc_cnt = (drive_q && ch.ovc && !trip) ? ovc_cnt + 1'b1 : '0;
    next_cmd_q   = ch.cmd;
    // Cut-off is set by a trip and lifted by a command toggle or by a
    // diagnosis read with the command still high; the trip wins.
    if (trip) begin
      next_shut = 1'b1;
    end else if ((ch.cmd && !cmd_q) || (ch.diag_rd && ch.cmd)) begin
      next_shut = 1'b0;
    end else begin
      next_shut = shut;
    end
    next_drive = ch.cmd && !next_shut;
    // Mask restarts at every switch-off and counts down while off.
    if (drive_q && !next_drive) begin
      next_mask_cnt = MW'(MASK_N);
    end else if (!drive_q && mask_cnt != '0) begin
      next_mask_cnt = mask_cnt - 1'b1;
    end else begin
      next_mask_cnt = mask_cnt;
    end
    // Comparator window: low is short to ground, between is open load.
    raw = ch.cmp_high ? FLT_NONE : (ch.cmp_low ? FLT_SCG : FLT_OL);
    qual = !drive_q && (mask_cnt == '0) && (raw != FLT_NONE);
    off_evt = qual && (raw == cand) && (off_cnt == DW'(DIAG_N - 1));
    next_cand = raw;
    if (!qual || raw != cand) begin
      next_off_cnt = '0;
    end else if (!off_evt) begin
      next_off_cnt = off_cnt + 1'b1;
    end else begin
      next_off_cnt = off_cnt;
    end
    // Read clears, but a fault found in the same cycle still lands.
    base = ch.diag_rd ? FLT_NONE : code;
    if (trip) begin
      next_code = FLT_SGB;
    end else if (off_evt && base == FLT_NONE) begin
      next_code = raw;
    end else begin
      next_code = base;
    end
  end

  // Registers for the channel.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q    <= 1'b0;
      shut     <= 1'b0;
      drive_q  <= 1'b0;
      ovc_cnt  <= '0;
      mask_cnt <= '0;
      off_cnt  <= '0;
      cand     <= FLT_NONE;
      code     <= FLT_NONE;
    end else begin
      cmd_q    <= next_cmd_q;
      shut     <= next_shut;
      drive_q  <= next_drive;
      ovc_cnt  <= next_ovc_cnt;
      mask_cnt <= next_mask_cnt;
      off_cnt  <= next_off_cnt;
      cand     <= next_cand;
      code     <= next_code;
    end
  end

  assign ch.drive = drive_q;
  assign ch.code  = code;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_OVC_TRIP: assert property (trip |=> shut && !drive_q && code == FLT_SGB)
    else $error("overcurrent trip did not cut off and latch");
  AST_DIAG_CLR: assert property (ch.diag_rd && !trip && !off_evt |=> code == FLT_NONE)
    else $error("diagnosis read did not clear the code");
  AST_FIRST_KEEP: assert property (code != FLT_NONE && !ch.diag_rd && !trip
      |=> code == $past(code))
    else $error("latched fault overwritten");
  AST_MASK: assert property ($fell(drive_q) |-> !off_evt [*8])
    else $error("off diagnosis inside mask delay");
  AST_TOGGLE: assert property (shut && ch.cmd && !cmd_q && !trip |=> drive_q)
    else $error("command toggle did not restart");
  AST_READ_RESTART: assert property (shut && ch.diag_rd && ch.cmd && !trip |=> drive_q)
    else $error("diagnosis read did not restart");
  COV_TRIP: cover property (trip ##[1:20] drive_q);
  COV_OFF_FAULT: cover property (off_evt);
endmodule

`default_nettype wire

// ===== hdl/rld_chan_if.sv
// Purpose: Carrier between the control top and one channel engine.
// Assumes: Single clock domain; all signals are sampled on clk_i.
// Notes:   The top drives commands and comparator levels, the channel answers.

`timescale 1ns/1ps
`default_nettype none

interface rld_chan_if;
  logic       cmd;       // Effective command after forcing and hold.
  logic       ovc;       // Load current above overcurrent threshold.
  logic       cmp_low;   // Output voltage below the low threshold.
  logic       cmp_high;  // Output voltage above the high threshold.
  logic       diag_rd;   // One-cycle diagnosis read pulse.
  logic       drive;     // Driver gate on.
  logic [1:0] code;      // Latched fault code.

  modport ctl  (output cmd, ovc, cmp_low, cmp_high, diag_rd, input drive, code);
  modport chan (input cmd, ovc, cmp_low, cmp_high, diag_rd, output drive, code);
endinterface

`default_nettype wire

// ===== hdl/rld_pkg.sv
// Purpose: Shared constants and types for the relay low-side control block.
// Assumes: 250 MHz clock; channel index 0 is relay output 13, index 5 is 18.
// Notes:   Derived cycle counts are computed from the printed times.

`default_nettype none

package rld_pkg;

  // ==========================================================================
  // Sizes and clock.
  localparam int NUM_CH  = 6;    // Six relay driver channels.
  localparam int CLK_MHZ = 250;  // Clock rate in MHz.

  // ==========================================================================
  // Times in their own units, and counts derived from them.
  localparam int OVC_FILT_NS   = 4000;    // Overcurrent filter time, typical.
  localparam int OVC_FILT_CYC  = OVC_FILT_NS * CLK_MHZ / 1000;
  localparam int DIAG_FILT_NS  = 50000;   // Off-state diagnosis filter, typical.
  localparam int DIAG_FILT_CYC = DIAG_FILT_NS * CLK_MHZ / 1000;
  localparam int MASK_NS       = 300000;  // Least mask delay after switch-off.
  localparam int MASK_CYC      = (MASK_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_MS       = 400;     // Least low-battery hold interval.
  localparam int HOLD_CYC      = HOLD_MS * CLK_MHZ * 1000;

  // ==========================================================================
  // Register byte offsets on the bus.
  localparam logic [3:0] ADR_CMD  = 4'h0;  // Channel command bits.
  localparam logic [3:0] ADR_CFG  = 4'h4;  // Configuration register seven.
  localparam logic [3:0] ADR_DIAG = 4'h8;  // Fault codes, read clears.
  localparam logic [3:0] ADR_STAT = 4'hc;  // Drive and hold state.

  // Register field positions and reset values.
  localparam int CFG_DIS_BIT  = 0;  // Global output disable.
  localparam int CFG_LB13_BIT = 1;  // Channel 13 low-battery hold enable.
  localparam int CFG_LB14_BIT = 2;  // Channel 14 low-battery hold enable.
  localparam int STAT_HOLD_LSB = 8; // Hold flags start here in the status word.
  localparam logic [5:0] CMD_RST = 6'h00;
  localparam logic [2:0] CFG_RST = 3'h0;

  // ==========================================================================
  // Two-bit fault codes.
  localparam logic [1:0] FLT_NONE = 2'h3;  // No fault.
  localparam logic [1:0] FLT_OL   = 2'h1;  // Open load.
  localparam logic [1:0] FLT_SGB  = 2'h2;  // Short to battery or overcurrent.
  localparam logic [1:0] FLT_SCG  = 2'h0;  // Short to ground.

  // Low-battery hold machine states, one-hot.
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'h1,
    HOLD_RUN  = 2'h2
  } rld_hold_t;

endpackage

`default_nettype wire

// ===== hdl/rld_top.sv
// Purpose: Control and diagnosis for six protected low-side relay channels.
// Assumes: Classic Wishbone slave, 32-bit data, synchronous active-high reset.
// Notes:   Channel 13 is index 0 and channel 14 is index 1 throughout.
//
// Operation
// - Six channels follow host command bits.
// - Device reset or global disable forces off.
// - Channels 13/14 hold on during low-battery reset.
// - Hold expiry without host retake switches off.
// - Separate hold enables for channels 13, 14.
// - Each channel stores a 2-bit fault code.
// - On watches overcurrent; off watches load.
// - Diagnosis read clears latched codes.
// - Off-state first fault kept; on-fault overwrites.
// - Filtered overcurrent cuts off, latches fault.
// - Command low-then-high restarts after cut-off.
// - Diagnosis read restarts if command high.
// - Off-state faults filtered about 50 us.
// - Off-state diagnosis masked after switch-off.
// - 11 ok, 01 open, 10 short, 00 ground.
// - Comparator window maps to ground, open, ok.
//
// Local design decisions: the Wishbone register port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module rld_top
  import rld_pkg::*;
#(
  parameter int HOLD_N = HOLD_CYC,      // Low-battery hold length in cycles.
  parameter int DIAG_N = DIAG_FILT_CYC, // Off-state filter in cycles.
  parameter int MASK_N = MASK_CYC,      // Mask delay in cycles.
  parameter int OVC_N  = OVC_FILT_CYC   // Overcurrent filter in cycles.
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave.
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Device side.
  input  wire logic                 device_reset_signal_i,
  input  wire logic                 battery_low_level_i,
  input  wire logic                 mcu_reset_n_i,
  input  wire logic [NUM_CH-1:0]    overcurrent_threshold_i,
  input  wire logic [NUM_CH-1:0]    out_below_low_i,
  input  wire logic [NUM_CH-1:0]    out_above_high_i,
  output logic      [NUM_CH-1:0]    drive_on_o,
  output logic      [1:0]           hold_active_o
);
  localparam int HW = $clog2(HOLD_N + 1);

  // ==========================================================================
  // Bus slave state.
  logic        ack;        // Answer flag, one cycle per request.
  logic [31:0] rdata;      // Read data captured at request take.
  logic        next_ack;
  logic [31:0] next_rdata;
  logic        req;        // New request being taken this cycle.
  logic        wr_acc;     // Write taking effect this cycle.
  logic        diag_rd;    // Diagnosis read pulse.

  // ==========================================================================
  // Control registers and channel views.
  logic [NUM_CH-1:0]   cmd, next_cmd;    // Host command bits.
  logic [2:0]          cfg, next_cfg;    // Disable and hold enables.
  logic [NUM_CH-1:0]   eff;              // Effective command to channels.
  logic [NUM_CH-1:0]   drive;            // Gate state from channels.
  logic [2*NUM_CH-1:0] codes;            // All fault codes.
  logic                force_off;        // Reset or disable forcing.
  logic                retake;           // Host rewrote the command register.
  logic                mrst_q;           // Previous micro reset level.

  // ==========================================================================
  // Hold machines for channels 13 and 14.
  rld_hold_t           hstate [2];
  rld_hold_t           next_hstate [2];
  logic [HW-1:0]       hcnt [2];
  logic [HW-1:0]       next_hcnt [2];
  logic [1:0]          trig, expire, hold_on, lb_en;

  assign req     = wb_cyc_i && wb_stb_i && !ack;
  assign wr_acc  = wb_cyc_i && wb_stb_i && ack && wb_we_i && wb_sel_i[0];
  assign diag_rd = req && !wb_we_i && (wb_adr_i == ADR_DIAG);
  assign retake  = wr_acc && (wb_adr_i == ADR_CMD);
  assign lb_en   = {cfg[CFG_LB14_BIT], cfg[CFG_LB13_BIT]};

  // Bus answer: ack one cycle after take, read data frozen with it. Unmapped
  // addresses read zero and still answer, so a stray access never hangs.
  always_comb begin
    next_ack   = req;
    next_rdata = rdata;
    if (req) begin
      case (wb_adr_i)
        ADR_CMD:  next_rdata = {26'h0, cmd};
        ADR_CFG:  next_rdata = {29'h0, cfg};
        ADR_DIAG: next_rdata = {20'h0, codes};
        ADR_STAT: next_rdata = {22'h0, hold_on, 2'h0, drive};
        default:  next_rdata = 32'h0;
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Command and configuration writes land at the acknowledged edge. A hold
  // expiry clears its command bit so the channel stays off afterwards.
  always_comb begin
    next_cmd = cmd;
    next_cfg = cfg;
    if (wr_acc && wb_adr_i == ADR_CMD) begin
      next_cmd = wb_dat_i[NUM_CH-1:0];
    end
    if (wr_acc && wb_adr_i == ADR_CFG) begin
      next_cfg = wb_dat_i[2:0];
    end
    if (!retake) begin
      next_cmd[1:0] = next_cmd[1:0] & ~expire;
    end
  end

  // Control registers; the micro reset level is kept for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd    <= CMD_RST;
      cfg    <= CFG_RST;
      mrst_q <= 1'b1;
    end else begin
      cmd    <= next_cmd;
      cfg    <= next_cfg;
      mrst_q <= mcu_reset_n_i;
    end
  end

  // Each hold machine arms on the falling edge of the micro reset while
  // battery is low and its channel is driving, then counts to the interval.
  // Limitation: a held channel ignores the device reset but not the global
  // disable, since software set that bit on purpose.
  for (genvar h = 0; h < 2; h++) begin : g_hold
    always_comb begin
      trig[h]   = lb_en[h] && battery_low_level_i && mrst_q && !mcu_reset_n_i
                  && drive[h] && (hstate[h] == HOLD_IDLE);
      expire[h] = 1'b0;
      next_hstate[h] = hstate[h];
      next_hcnt[h]   = hcnt[h];
      case (hstate[h])
        HOLD_IDLE: begin
          next_hcnt[h] = '0;
          if (trig[h]) begin
            next_hstate[h] = HOLD_RUN;
          end
        end
        HOLD_RUN: begin
          if (retake) begin
            next_hstate[h] = HOLD_IDLE;
          end else if (hcnt[h] == HW'(HOLD_N - 1)) begin
            expire[h]      = 1'b1;
            next_hstate[h] = HOLD_IDLE;
          end else begin
            next_hcnt[h] = hcnt[h] + 1'b1;
          end
        end
        default: begin
          next_hstate[h] = HOLD_IDLE;
        end
      endcase
      hold_on[h] = (hstate[h] == HOLD_RUN) || trig[h];
    end

    // Hold machine registers.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        hstate[h] <= HOLD_IDLE;
        hcnt[h]   <= '0;
      end else begin
        hstate[h] <= next_hstate[h];
        hcnt[h]   <= next_hcnt[h];
      end
    end
  end

  // Forcing: global disable turns every channel off; device reset turns off all but a held channel 13 or 14.
  assign force_off = device_reset_signal_i || cfg[CFG_DIS_BIT];

  // ==========================================================================
  // Channel engines.
  rld_chan_if ch_if [NUM_CH] ();

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    if (c < 2) begin : g_held
      assign eff[c] = (cmd[c] && !force_off)
                      || (hold_on[c] && !cfg[CFG_DIS_BIT]);
    end else begin : g_plain
      assign eff[c] = cmd[c] && !force_off;
    end
    assign ch_if[c].cmd      = eff[c];
    assign ch_if[c].ovc      = overcurrent_threshold_i[c];
    assign ch_if[c].cmp_low  = out_below_low_i[c];
    assign ch_if[c].cmp_high = out_above_high_i[c];
    assign ch_if[c].diag_rd  = diag_rd;
    assign drive[c]          = ch_if[c].drive;
    assign codes[2*c +: 2]   = ch_if[c].code;

    rld_chan #(
      .OVC_N  (OVC_N),
      .DIAG_N (DIAG_N),
      .MASK_N (MASK_N)
    ) u_chan (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ch    (ch_if[c])
    );
  end

  assign wb_ack_o      = ack;
  assign wb_dat_o      = rdata;
  assign drive_on_o    = drive;
  assign hold_active_o = {hstate[1] == HOLD_RUN, hstate[0] == HOLD_RUN};

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DISABLE_OFF: assert property (cfg[CFG_DIS_BIT] |=> drive_on_o == 6'h00)
    else $error("global disable did not force channels off");
  AST_RESET_OFF: assert property (device_reset_signal_i |=> drive_on_o[5:2] == 4'h0)
    else $error("device reset did not force channels off");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  for (genvar h = 0; h < 2; h++) begin : g_hchk
    // A held gate may still be cut by its own overcurrent filter, so the
    // check only covers a driving channel with no overcurrent this cycle.
    AST_HOLD_KEEP: assert property (hstate[h] == HOLD_RUN && !cfg[CFG_DIS_BIT]
        && drive_on_o[h] && !overcurrent_threshold_i[h] |=> drive_on_o[h])
      else $error("held channel dropped during hold");
    AST_HOLD_EXPIRE: assert property (expire[h] |-> ##2 !drive_on_o[h])
      else $error("channel still on after hold expiry");
    AST_HOLD_EN: assert property ($rose(hstate[h] == HOLD_RUN) |-> $past(lb_en[h]))
      else $error("hold started while disabled");
  end

  COV_HOLD_RETAKE: cover property (hstate[0] == HOLD_RUN ##1 retake);
  COV_DIAG_READ: cover property (diag_rd && codes != 12'hfff);
  COV_HOLD_EXPIRE: cover property (expire[1]);
endmodule

`default_nettype wire
